// file: cir_core.sv
// Purpose: interrupt, test and reset input handling for the instruction sequencer
// Assumes: sequencer marks last cycle of each instruction and wait execution
// Notes:   reset pin is active high; rstn is the power-on core reset
`timescale 1ns/1ns
module cir_core (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       reset_pin,
  input  wire logic       maskable_irq_in,
  input  wire logic       nmi_in,
  input  wire logic       test_n_in,
  input  wire logic       if_flag,
  input  wire logic       instr_last,
  input  wire logic       wait_exec,
  input  wire logic       ack_done,
  input  wire logic       vec_done,
  output logic            ack_start,
  output logic            vec_start,
  output logic [7:0]      vec_type,
  output logic            nmi_taken,
  output logic            wait_idle,
  output logic            abort,
  output logic            restart,
  output logic            core_in_reset
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic nmi_s;
  logic test_n_s;
  logic reset_s;
  logic irq_hold_reg;
  logic nmi_pend;
  logic nmi_clear;
  logic [2:0] rst_cnt_reg;
  logic irq_take;
  logic nmi_take;
  cir_pkg::cir_state_t state_reg;
  cir_pkg::cir_state_t state_next;

  // nmi through three flops and a qualified output flop before edge detect
  cir_sync3 u_nmi_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (nmi_in),
    .dout  (nmi_s)
  );

  // test resynchronised on every rising clock edge
  cir_sync3 u_test_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (test_n_in),
    .dout  (test_n_s)
  );

  // reset pin is sampled, never used as an async clear
  cir_sync3 u_rst_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   (reset_pin),
    .dout  (reset_s)
  );

  // ************************************************************
  // nmi edge latch
  // ************************************************************
  assign nmi_clear = nmi_take;

  cir_edge_latch u_nmi_edge (
    .clock   (clock),
    .rstn    (rstn),
    .level   (nmi_s),
    .clear   (nmi_clear),
    .pending (nmi_pend)
  );

  // ************************************************************
  // maskable request sampling
  // ************************************************************
  // level pin sampled once per instruction; short requests may be missed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_hold_reg <= cir_pkg::SYNC_RST_VAL;
    end else if (instr_last) begin
      irq_hold_reg <= maskable_irq_in;
    end
  end

  // decisions at the instruction boundary; nmi wins over maskable
  assign nmi_take = (state_reg == cir_pkg::CIR_RUN) && instr_last && nmi_pend;
  assign irq_take = (state_reg == cir_pkg::CIR_RUN) && instr_last && !nmi_pend
                    && maskable_irq_in && if_flag;

  // ************************************************************
  // reset hold counter
  // ************************************************************
  // counts synchronised high clocks; the source must give at least four
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_cnt_reg <= cir_pkg::CNT_RST_VAL;
    end else if (!reset_s) begin
      rst_cnt_reg <= cir_pkg::CNT_RST_VAL;
    end else if (rst_cnt_reg != cir_pkg::RESET_CNT_MAX) begin
      rst_cnt_reg <= rst_cnt_reg + 3'h1;
    end
  end

  // ************************************************************
  // sequencer state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cir_pkg::CIR_RUN: begin
        if (nmi_take) begin
          state_next = cir_pkg::CIR_VEC;
        end else if (irq_take) begin
          state_next = cir_pkg::CIR_ACK;
        end else if (wait_exec && test_n_s) begin
          state_next = cir_pkg::CIR_IDLE;
        end
      end
      cir_pkg::CIR_ACK: begin
        if (ack_done) begin
          state_next = cir_pkg::CIR_VEC;
        end
      end
      cir_pkg::CIR_VEC: begin
        if (vec_done) begin
          state_next = cir_pkg::CIR_RUN;
        end
      end
      cir_pkg::CIR_IDLE: begin
        if (!test_n_s) begin
          state_next = cir_pkg::CIR_RUN;
        end
      end
      cir_pkg::CIR_RST: begin
        state_next = cir_pkg::CIR_RUN;
      end
      default: begin
        state_next = cir_pkg::CIR_RST;
      end
    endcase
    if (reset_s) begin
      state_next = cir_pkg::CIR_RST;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= cir_pkg::CIR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  // vector type captured when the service is chosen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      vec_type <= cir_pkg::VEC_RST_VAL;
    end else if (nmi_take) begin
      vec_type <= cir_pkg::NMI_TYPE;
    end else if (irq_take) begin
      vec_type <= cir_pkg::VEC_RST_VAL;
    end
  end

  // one-cycle pulses and levels from the state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_start     <= 1'h0;
      vec_start     <= 1'h0;
      nmi_taken     <= 1'h0;
      abort         <= 1'h0;
      restart       <= 1'h0;
      wait_idle     <= 1'h0;
      core_in_reset <= 1'h1;
    end else begin
      ack_start     <= irq_take && !reset_s;
      vec_start     <= (nmi_take || (state_reg == cir_pkg::CIR_ACK && ack_done)) && !reset_s;
      nmi_taken     <= nmi_take && !reset_s;
      abort         <= reset_s && (state_reg != cir_pkg::CIR_RST);
      restart       <= (state_reg == cir_pkg::CIR_RST) && !reset_s;
      wait_idle     <= (state_next == cir_pkg::CIR_IDLE);
      core_in_reset <= (state_next == cir_pkg::CIR_RST);
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic irq_acc_d;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_acc_d <= 1'h0;
    end else begin
      irq_acc_d <= irq_take;
    end
  end

  irq_at_boundary_a: assert property (@(posedge clock) disable iff (!rstn)
    ack_start |-> $past(instr_last))
    else $error("ack started outside an instruction boundary");
  irq_ack_start_a: assert property (@(posedge clock) disable iff (!rstn)
    irq_acc_d && !$past(reset_s) |-> ack_start)
    else $error("accepted request gave no acknowledge");
  // the level latched at the last boundary must back every acknowledge
  irq_level_a: assert property (@(posedge clock) disable iff (!rstn)
    ack_start |-> irq_hold_reg)
    else $error("acknowledge without a request at the boundary");
  nmi_boundary_a: assert property (@(posedge clock) disable iff (!rstn)
    nmi_taken |-> $past(instr_last))
    else $error("nmi taken outside an instruction boundary");
  irq_masked_a: assert property (@(posedge clock) disable iff (!rstn)
    ack_start |-> $past(if_flag))
    else $error("acknowledge while enable flag clear");
  nmi_type_a: assert property (@(posedge clock) disable iff (!rstn)
    nmi_taken |-> vec_type == cir_pkg::NMI_TYPE && vec_start)
    else $error("nmi did not vector as type 2");
  nmi_edge_delay_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(nmi_s) |-> $past(nmi_in, 3))
    else $error("nmi edge seen before synchroniser");
  nmi_unmasked_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == cir_pkg::CIR_RUN && instr_last && nmi_pend && !reset_s
    |=> nmi_taken)
    else $error("pending nmi not serviced at boundary");
  nmi_held_a: assert property (@(posedge clock) disable iff (!rstn)
    nmi_pend && !nmi_take |=> nmi_pend)
    else $error("pending nmi lost");
  wait_release_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == cir_pkg::CIR_IDLE && !test_n_s && !reset_s
    |=> state_reg == cir_pkg::CIR_RUN)
    else $error("idle not left when test went low");
  wait_enter_a: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == cir_pkg::CIR_RUN && wait_exec && test_n_s && !instr_last && !reset_s
    |=> wait_idle)
    else $error("wait with test high did not idle");
  // counter saturates only if the source kept reset high long enough
  reset_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    $fell(reset_s) |-> rst_cnt_reg == cir_pkg::RESET_CNT_MAX)
    else $error("reset released before the minimum hold");
  reset_abort_a: assert property (@(posedge clock) disable iff (!rstn)
    reset_s |=> state_reg == cir_pkg::CIR_RST ##0 core_in_reset)
    else $error("reset did not abandon operation");
  reset_resume_a: assert property (@(posedge clock) disable iff (!rstn)
    rstn && state_reg == cir_pkg::CIR_RST && !reset_s
    |=> state_reg == cir_pkg::CIR_RUN && restart)
    else $error("no restart after reset release");

  irq_service_c: cover property (@(posedge clock) disable iff (!rstn)
    ack_start ##[1:20] vec_start);
  nmi_service_c: cover property (@(posedge clock) disable iff (!rstn) nmi_taken);
  wait_idle_c: cover property (@(posedge clock) disable iff (!rstn)
    wait_idle ##1 !wait_idle);
  reset_cycle_c: cover property (@(posedge clock) disable iff (!rstn)
    abort ##[1:20] restart);
endmodule

// file: cir_core_tb.sv
// Purpose: self-checking bench for the interrupt, test and reset inputs
// Assumes: bench plays the instruction sequencer, model plays the pins
// Notes:   outputs are judged at the falling edge, once settled
`timescale 1ns/1ns
module cir_core_tb;
  logic       clock, rstn, if_flag, instr_last, wait_exec, ack_done, vec_done;
  logic       reset_pin, maskable_irq_in, nmi_in, test_n_in;
  logic       ack_start, vec_start, nmi_taken, wait_idle, abort, restart, core_in_reset;
  logic [7:0] vec_type;
  logic [6:0] outs;
  int         errors, n_compared;
  // one vector so a single poll task serves every flag
  assign outs = {core_in_reset, restart, abort, wait_idle, nmi_taken, vec_start, ack_start};
  // one clock for all timing; even duty, as the design uses rising edges and the bench judges at falling ones
  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  cir_ext_src src (.clock(clock), .reset_pin(reset_pin), .maskable_irq_in(maskable_irq_in),
                   .nmi_in(nmi_in), .test_n_in(test_n_in));
  cir_core dut (.clock(clock), .rstn(rstn), .reset_pin(reset_pin),
                .maskable_irq_in(maskable_irq_in), .nmi_in(nmi_in), .test_n_in(test_n_in),
                .if_flag(if_flag), .instr_last(instr_last), .wait_exec(wait_exec),
                .ack_done(ack_done), .vec_done(vec_done), .ack_start(ack_start),
                .vec_start(vec_start), .vec_type(vec_type), .nmi_taken(nmi_taken),
                .wait_idle(wait_idle), .abort(abort), .restart(restart),
                .core_in_reset(core_in_reset));
  // ****************
  // compare helpers
  // ****************
  task automatic check_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // bounded poll: a flag that never arrives still ends in a compare
  task automatic wait_val(input string what, input int idx, input logic val, input int max);
    int k;
    k = 0;
    @(negedge clock);
    while (outs[idx] !== val && k < max) begin
      @(negedge clock);
      k++;
    end
    check_bit(what, val, outs[idx]);
  endtask
  // one instruction's last cycle; same-clock inputs move just after the edge
  task automatic boundary();
    @(posedge clock);
    instr_last <= 1'h1;
    @(posedge clock);
    instr_last <= 1'h0;
  endtask
  task automatic strobe_done(input logic vec);
    @(posedge clock);
    ack_done <= ~vec;
    vec_done <= vec;
    @(posedge clock);
    ack_done <= 1'h0;
    vec_done <= 1'h0;
  endtask
  // *********
  // scenarios
  // *********
  task automatic t_irq();
    src.set_levels(1'h1, 1'h1);
    if_flag <= 1'h1;
    repeat (3) @(negedge clock) check_bit("ack mid instr", 1'h0, ack_start);
    boundary();
    @(negedge clock) check_bit("ack_start", 1'h1, ack_start);
    strobe_done(1'h0);
    src.set_levels(1'h0, 1'h1);
    @(negedge clock) check_bit("vec_start", 1'h1, vec_start);
    check_byte("vec_type irq", 8'h00, vec_type);
    strobe_done(1'h1);
  endtask
  // maskable request with the enable flag clear
  task automatic t_masked();
    src.set_levels(1'h1, 1'h1);
    if_flag <= 1'h0;
    boundary();
    repeat (2) @(negedge clock) check_bit("ack masked", 1'h0, ack_start);
  endtask
  // short nmi while masked and with a maskable request up
  task automatic t_nmi();
    @(posedge clock);
    src.nmi_pulse();
    repeat (6) @(posedge clock);
    @(negedge clock) check_bit("nmi early", 1'h0, nmi_taken);
    boundary();
    @(negedge clock) check_bit("nmi_taken", 1'h1, nmi_taken);
    check_bit("nmi vec_start", 1'h1, vec_start);
    check_byte("vec_type nmi", cir_pkg::NMI_TYPE, vec_type);
    check_bit("nmi no ack", 1'h0, ack_start);
    strobe_done(1'h1);
    src.set_levels(1'h0, 1'h1);
  endtask
  task automatic t_wait();
    @(posedge clock);
    wait_exec <= 1'h1;
    @(posedge clock);
    wait_exec <= 1'h0;
    repeat (4) @(negedge clock) check_bit("wait_idle", 1'h1, wait_idle);
    @(posedge clock);
    src.set_levels(1'h0, 1'h0);
    repeat (3) @(negedge clock) check_bit("test synced", 1'h1, wait_idle);
    wait_val("wait released", 3, 1'h0, 8);
    // wait with test already low must not idle
    @(posedge clock);
    wait_exec <= 1'h1;
    @(posedge clock);
    wait_exec <= 1'h0;
    repeat (2) @(negedge clock) check_bit("wait test low", 1'h0, wait_idle);
    @(posedge clock);
    src.set_levels(1'h0, 1'h1);
  endtask
  task automatic t_reset();
    @(posedge clock);
    fork
      src.reset_hold(6);
      begin
        repeat (4) @(negedge clock) check_bit("abort early", 1'h0, abort);
        wait_val("abort", 4, 1'h1, 8);
        check_bit("core_in_reset", 1'h1, core_in_reset);
      end
    join
    wait_val("restart", 5, 1'h1, 12);
    check_bit("out of reset", 1'h0, core_in_reset);
  endtask
  task automatic report_and_stop();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence; requests start two edges after reset release
  initial begin
    rstn       = 1'h0;
    if_flag    = 1'h0;
    instr_last = 1'h0;
    wait_exec  = 1'h0;
    ack_done   = 1'h0;
    vec_done   = 1'h0;
    errors     = 0;
    n_compared = 0;
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    repeat (2) @(posedge clock);
    t_irq();
    t_masked();
    t_nmi();
    t_wait();
    t_reset();
    report_and_stop();
  end
  // watchdog; the whole run needs under a hundred clocks
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    report_and_stop();
  end
endmodule

// file: cir_edge_latch.sv
// Purpose: rising edge detector with sticky pending flag
// Assumes: input already synchronised to clock
// Notes:   a new edge in the clearing cycle wins over the clear
`timescale 1ns/1ns
module cir_edge_latch (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic level,
  input  wire logic clear,
  output logic      pending
);
  logic prev_reg;
  logic rise;

  // previous level for edge detection
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prev_reg <= cir_pkg::SYNC_RST_VAL;
    end else begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;

  // sticky flag so a short pulse is never lost
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'h0;
    end else if (rise) begin
      pending <= 1'h1;
    end else if (clear) begin
      pending <= 1'h0;
    end
  end
endmodule

// file: cir_ext_src.sv
// Purpose: model of the outside interrupt, test and reset sources
// Assumes: tasks are called just after a rising clock edge
// Notes:   reset is never held high for less than the minimum
`timescale 1ns/1ns
module cir_ext_src (
  input  wire logic clock,
  output logic      reset_pin,
  output logic      maskable_irq_in,
  output logic      nmi_in,
  output logic      test_n_in
);
  // ************
  // source model
  // ************
  // idle levels: no request, test high so a wait idles
  initial begin
    reset_pin       = 1'h0;
    maskable_irq_in = 1'h0;
    nmi_in          = 1'h0;
    test_n_in       = 1'h1;
  end
  // plain levels for the maskable request and the test pin
  task automatic set_levels(input logic irq, input logic tst_n);
    maskable_irq_in <= irq;
    test_n_in       <= tst_n;
  endtask
  // short nmi pulse; long enough to pass the synchroniser only
  task automatic nmi_pulse();
    nmi_in <= 1'h1;
    repeat (3) @(posedge clock);
    nmi_in <= 1'h0;
  endtask
  // hold reset high n clocks, clipped up to the minimum
  task automatic reset_hold(input int n);
    reset_pin <= 1'h1;
    repeat ((n < cir_pkg::RESET_MIN_CLK) ? cir_pkg::RESET_MIN_CLK : n) @(posedge clock);
    reset_pin <= 1'h0;
  endtask
endmodule

// file: cir_pkg.sv
// Purpose: constants for the interrupt, test and reset input logic of the cpu
// Assumes: single 250 MHz clock, active low asynchronous core reset
// Notes:   rule summary follows
// Operation
// - maskable request is a level, sampled only in an instruction's last cycle
// - accepted maskable request runs an acknowledge, then vectors to handler
// - maskable request ignored while interrupt enable flag is clear
// - rising nmi edge raises a type 2 interrupt through the vector table
// - nmi low-to-high triggers; service starts after current instruction ends
// - interrupt enable flag never masks nmi
// - nmi synchronised to the clock before edge detection
// - wait instruction proceeds when test is low, else idles re-checking it
// - test input synchronised every clock before use
// - active reset abandons any operation at once
// - execution resumes from restart point after reset returns low
// - reset input synchronised to the clock before acting
package cir_pkg;
  // interrupt type numbers
  localparam logic [7:0] NMI_TYPE      = 8'h02;
  // minimum reset high time in clocks
  localparam int         RESET_MIN_CLK = 4;
  localparam logic [2:0] RESET_CNT_MAX = 3'h4;
  // reset values
  localparam logic       SYNC_RST_VAL  = 1'h0;
  localparam logic [2:0] CNT_RST_VAL   = 3'h0;
  localparam logic [7:0] VEC_RST_VAL   = 8'h00;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    CIR_RUN  = 5'h01,
    CIR_ACK  = 5'h02,
    CIR_VEC  = 5'h04,
    CIR_IDLE = 5'h08,
    CIR_RST  = 5'h10
  } cir_state_t;
endpackage

// file: cir_sync3.sv
// Purpose: three-flop synchroniser with change qualification
// Assumes: input is asynchronous to clock
// Notes:   output changes only once stages two and three agree
`timescale 1ns/1ns
module cir_sync3 (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic din,
  output logic      dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // stage one feeds only stage two, so metastability never reaches logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= cir_pkg::SYNC_RST_VAL;
      s2_reg <= cir_pkg::SYNC_RST_VAL;
      s3_reg <= cir_pkg::SYNC_RST_VAL;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // qualified output, held until two and three agree
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dout <= cir_pkg::SYNC_RST_VAL;
    end else if (s2_reg == s3_reg) begin
      dout <= s3_reg;
    end
  end
endmodule
